// >>> core/edm_dev.sv
`timescale 1ns/1ps
module edm_dev import edm_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  edm_if.dev               regs,
  input  wire logic        nmiPin,       // Asynchronous NMI pin
  input  wire logic        txUnderflow,  // Engine event pulses
  input  wire logic        rxOverflow,
  input  wire logic        addrIllegal,
  input  wire logic [31:0] liveRxBuf,    // Live engine addresses
  input  wire logic [31:0] liveRxDesc,
  input  wire logic [31:0] liveTxBuf,
  input  wire logic [31:0] liveTxDesc,
  output logic             dmaEnable,    // Engine may run
  output logic             softReset     // One-cycle soft reset pulse
);
  logic       nmiMeta;     // Sync stage 1
  logic       nmiSync;     // Sync stage 2
  logic       nmiPrev;     // Edge detect
  logic       fifoPolicy;  // Policy bit
  logic       addrErr;     // Stop flag
  logic       nmiHalted;   // Halt flag
  logic       fifoHalt;    // Halt from FIFO error
  edm_state_t state;       // Run state
  // Pointer snapshots, one per monitored address
  logic [31:0] rxBuf;      // Rx buffer write pointer
  logic [31:0] rxDesc;     // Rx descriptor fetch pointer
  logic [31:0] txBuf;      // Tx buffer read pointer
  logic [31:0] txDesc;     // Tx descriptor fetch pointer
  logic [3:0]  snapCnt;    // Snapshot interval counter
  logic        wrCtl;      // Write to operation control
  logic        wrMode;     // Write to mode register
  logic        softRstReq; // Mode write with soft reset bit set

  ////////////////////////////////////////////////////////////////////////
  // Soft reset decode, shared by every flag that it clears
  function automatic logic softRstDecode(logic isModeWr, logic [31:0] word);
    return isModeWr && word[EDM_BIT_SOFTRST];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Link decodes; the strobes qualify them, ce gates the flops
  assign wrCtl      = regs.wr && regs.addr == EDM_OFS_OPCTRL;
  assign wrMode     = regs.wr && regs.addr == EDM_OFS_MODE;
  assign softRstReq = softRstDecode(wrMode, regs.wdata);

  ////////////////////////////////////////////////////////////////////////
  // NMI pin synchroniser, two flops before any use
  // Edge, not level: a pin held high halts only once
  // Pin idles low, so the edge flop resets low and no false edge follows
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nmiMeta <= 1'b0;
      nmiSync <= 1'b0;
      nmiPrev <= 1'b0;
    end else if (ce) begin
      nmiMeta <= nmiPin;
      nmiSync <= nmiMeta;
      nmiPrev <= nmiSync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Operation control flags; hardware set beats software clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fifoPolicy <= 1'b0;
      addrErr    <= 1'b0;
      nmiHalted  <= 1'b0;
      fifoHalt   <= 1'b0;
    end else if (ce) begin
      // Policy is the only bit software sets directly
      if (wrCtl) begin
        fifoPolicy <= regs.wdata[EDM_BIT_POLICY];
      end
      // Address stop only clears through soft reset
      if (addrIllegal) begin
        addrErr <= 1'b1;
      end else if (softRstReq) begin
        addrErr <= 1'b0;  // Stop acknowledged by soft reset
      end
      // NMI halt, cleared by writing 0
      if (nmiSync && !nmiPrev) begin
        nmiHalted <= 1'b1;  // Rising edge of the synced pin
      end else if (wrCtl && !regs.wdata[EDM_BIT_HALTED]) begin
        nmiHalted <= 1'b0;
      end
      // FIFO error halts only under policy 1
      // Under policy 0 the event is dropped and the engine runs on
      if ((txUnderflow || rxOverflow) && fifoPolicy) begin
        fifoHalt <= 1'b1;
      end else if (softRstReq) begin
        fifoHalt <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Run state and engine enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state     <= EDM_RUN;
      dmaEnable <= 1'b0;
      softReset <= 1'b0;
    end else if (ce) begin
      // Soft reset pulse trails the mode write by one cycle
      softReset <= softRstReq;
      // Leaving EDM_RUN, address stop outranks NMI halt, which outranks FIFO halt
      case (state)
        EDM_RUN: begin
          if (addrErr) begin
            state <= EDM_ADDR_STOP;
          end else if (nmiHalted) begin
            state <= EDM_NMI_HALT;
          end else if (fifoHalt) begin
            state <= EDM_FIFO_HALT;
          end
        end
        EDM_NMI_HALT: begin
          // An address stop during the halt takes over
          if (addrErr) begin
            state <= EDM_ADDR_STOP;
          end else if (!nmiHalted) begin
            state <= EDM_RUN;
          end
        end
        default: begin
          // FIFO halt and address stop leave only once every flag is clear
          if (!addrErr && !fifoHalt && !nmiHalted) begin
            state <= EDM_RUN;
          end
        end
      endcase
      // Registered for a clean level; rises one cycle after state returns to EDM_RUN, drops on the same edge that state leaves it
      dmaEnable <= state == EDM_RUN && !addrErr && !nmiHalted && !fifoHalt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Snapshots refresh on an interval, so they lag on purpose
  // One interval copies all four at once, so they stay coherent
  // Fewer updates trade freshness for quieter flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      snapCnt <= 4'h0;
      rxBuf   <= EDM_RST_PTR;
      rxDesc  <= EDM_RST_PTR;
      txBuf   <= EDM_RST_PTR;
      txDesc  <= EDM_RST_PTR;
    end else if (ce) begin
      if (snapCnt == EDM_SNAP_CYCLES - 4'h1) begin
        snapCnt <= 4'h0;
        // Bus writes never touch these
        rxBuf   <= liveRxBuf;
        rxDesc  <= liveRxDesc;
        txBuf   <= liveTxBuf;
        txDesc  <= liveTxDesc;
      end else begin
        snapCnt <= snapCnt + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regs.rdata <= EDM_RST_WORD;
    end else if (ce) begin
      // Default zero covers mode, unmapped and idle cycles
      regs.rdata <= EDM_RST_WORD;
      if (regs.rd) begin
        if (regs.addr == EDM_OFS_OPCTRL) begin
          // Operation control assembled bit by bit
          // Reserved 31:4 and 0 stay zero
          regs.rdata[EDM_BIT_POLICY]  <= fifoPolicy;
          regs.rdata[EDM_BIT_ADDRERR] <= addrErr;
          regs.rdata[EDM_BIT_HALTED]  <= nmiHalted;
        end else if (regs.addr == EDM_OFS_RXBUF) begin
          regs.rdata <= rxBuf;
        end else if (regs.addr == EDM_OFS_RXDESC) begin
          regs.rdata <= rxDesc;
        end else if (regs.addr == EDM_OFS_TXBUF) begin
          regs.rdata <= txBuf;
        end else if (regs.addr == EDM_OFS_TXDESC) begin
          regs.rdata <= txDesc;
        end
      end
    end
  end
endmodule // edm_dev

// >>> core/edm_host.sv
`timescale 1ns/1ps
// Controller: software port in, engine register link out
module edm_host import edm_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [3:0]  swAddr,
  input  wire logic [31:0] swWdata,
  input  wire logic        swWr,
  input  wire logic        swRd,
  output logic [31:0]      swRdata,
  edm_if.host              link
);
  logic        fwdPend;  // Engine read data stand this cycle
  logic        ctlRd;    // Software read of a local index
  logic [31:0] lastRead; // Last engine word seen
  logic [31:0] ctlWord;  // Local read value, zero when idle

  ////////////////////////////////////////////////////////////////////////
  // Forward in the same cycle, so read data keep one cycle of latency
  assign link.addr  = swAddr;
  assign link.wdata = swWdata;
  // Monitor pointers and local indices never see a write
  assign link.wr = swWr && swAddr < EDM_OFS_HSTAT && swAddr != EDM_OFS_RXBUF
                   && swAddr != EDM_OFS_RXDESC && swAddr != EDM_OFS_TXBUF
                   && swAddr != EDM_OFS_TXDESC;
  // Local indices stay on this side
  assign link.rd = swRd && swAddr < EDM_OFS_HSTAT;
  assign ctlRd   = swRd && swAddr >= EDM_OFS_HSTAT;
  // Both sources are zero outside their answer cycle, so OR merges them
  assign swRdata = link.rdata | ctlWord;

  ////////////////////////////////////////////////////////////////////////
  // Local read return; bypass covers a local read right after an engine read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fwdPend  <= 1'b0;
      ctlWord  <= EDM_RST_WORD;
      lastRead <= EDM_RST_WORD;
    end else if (ce) begin
      fwdPend <= link.rd;
      if (fwdPend) begin
        lastRead <= link.rdata;
      end
      if (ctlRd && fwdPend) begin
        ctlWord <= link.rdata;
      end else if (ctlRd) begin
        ctlWord <= lastRead;
      end else begin
        ctlWord <= EDM_RST_WORD;
      end
    end
  end
endmodule // edm_host

// >>> core/edm_if.sv
`timescale 1ns/1ps
// Register access link between controller and engine
interface edm_if;
  logic [3:0]  addr;   // Register index
  logic [31:0] wdata;  // Write data
  logic        wr;     // Write strobe
  logic        rd;     // Read strobe
  logic [31:0] rdata;  // Read data, cycle after rd
  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// >>> core/edm_pkg.sv
package edm_pkg;
  // Register indices on the shared register port
  localparam logic [3:0] EDM_OFS_OPCTRL = 4'h0;
  localparam logic [3:0] EDM_OFS_RXBUF  = 4'h1;
  localparam logic [3:0] EDM_OFS_RXDESC = 4'h2;
  localparam logic [3:0] EDM_OFS_TXBUF  = 4'h3;
  localparam logic [3:0] EDM_OFS_TXDESC = 4'h4;
  localparam logic [3:0] EDM_OFS_MODE   = 4'h5;
  localparam logic [3:0] EDM_OFS_HSTAT  = 4'h8;
  localparam logic [3:0] EDM_OFS_HCMD   = 4'h9;
  // Operation control bit positions
  localparam int EDM_BIT_POLICY = 3;
  localparam int EDM_BIT_ADDRERR = 2;
  localparam int EDM_BIT_HALTED = 1;
  // Mode register soft reset bit
  localparam int EDM_BIT_SOFTRST = 0;
  // Reset values
  localparam logic [31:0] EDM_RST_PTR = 32'h0000_0000;
  localparam logic [31:0] EDM_RST_WORD = 32'h0000_0000;
  // Snapshot refresh interval in cycles
  localparam logic [3:0] EDM_SNAP_CYCLES = 4'h4;
  // Engine run state
  typedef enum logic [1:0] {EDM_RUN, EDM_FIFO_HALT, EDM_ADDR_STOP, EDM_NMI_HALT} edm_state_t;
endpackage

// >>> verification/edm_asserts.sv
`timescale 1ns/1ps
// Link-side checks between controller and engine
module edm_asserts import edm_pkg::*; (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [3:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic pol;  // Last policy written; reset value is 0
  ////////////////////////////////////////////////////////////////////////
  // Policy shadow, only opctrl writes move it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) pol <= 1'h0;
    else if (wr && addr == EDM_OFS_OPCTRL) pol <= wdata[EDM_BIT_POLICY];
  end
  ////////////////////////////////////////////////////////////////////////
  a_strobe_excl: assert property (!(wr && rd))
    else $error("link strobes together");
  a_rdata_idle: assert property (!rd |=> rdata == 32'h0)
    else $error("read data without read");
  a_rsvd_zero: assert property (
    rd && addr == EDM_OFS_OPCTRL |=> rdata[31:4] == 28'h0 && !rdata[0])
    else $error("reserved bits not zero");
  a_policy_keep: assert property (
    rd && addr == EDM_OFS_OPCTRL |=> rdata[EDM_BIT_POLICY] == $past(pol))
    else $error("policy bit wrong");
  a_mon_ro: assert property (wr |-> !(addr inside {[4'h1:4'h4]}))
    else $error("monitor write reached engine");
  a_wr_range: assert property (wr |-> addr < 4'h8)
    else $error("local write reached engine");
  a_halt_clear: assert property (
    wr && addr == EDM_OFS_OPCTRL && !wdata[EDM_BIT_HALTED]
    ##1 rd && addr == EDM_OFS_OPCTRL |=> !rdata[EDM_BIT_HALTED])
    else $error("halted flag not cleared");
  a_aerr_clear: assert property (
    wr && addr == EDM_OFS_MODE && wdata[EDM_BIT_SOFTRST] ##1 wr
    ##1 rd && addr == EDM_OFS_OPCTRL |=> !rdata[EDM_BIT_ADDRERR])
    else $error("address error not cleared");
  // Main scenarios reached
  c_snap: cover property (rd && addr == EDM_OFS_RXBUF);
  c_srst: cover property (wr && addr == EDM_OFS_MODE);
  c_halt: cover property (rd ##1 rdata[EDM_BIT_HALTED]);
endmodule // edm_asserts

// >>> verification/tb.sv
`timescale 1ns/1ps
module tb import edm_pkg::*; ;
  logic        clk = 0, rst = 1, swWr = 0, swRd = 0, nmiPin = 0;
  logic        txUf = 0, rxOf = 0, aIll = 0, s1 = 0, s2 = 0;
  logic        dmaEnable, softReset;
  logic [3:0]  swAddr = 4'h0;
  logic [31:0] swWdata = 32'h0, swRdata, seed = 32'h32;
  logic [31:0] live [4] = '{default: 32'h0};  // Live engine addresses
  logic [31:0] expQ [$];                      // Expected read data
  int          errTotal = 0, checkCount = 0;
  edm_if link ();
  edm_host edm_host_inst (.clk(clk), .rst(rst), .ce(1'h1), .swAddr(swAddr),
    .swWdata(swWdata), .swWr(swWr), .swRd(swRd), .swRdata(swRdata), .link(link.host));
  edm_dev edm_dev_inst (.clk(clk), .rst(rst), .ce(1'h1), .regs(link.dev),
    .nmiPin(nmiPin), .txUnderflow(txUf), .rxOverflow(rxOf), .addrIllegal(aIll),
    .liveRxBuf(live[0]), .liveRxDesc(live[1]), .liveTxBuf(live[2]),
    .liveTxDesc(live[3]), .dmaEnable(dmaEnable), .softReset(softReset));
  edm_asserts edm_asserts_inst (.clk(clk), .rst(rst), .addr(link.addr),
    .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata));
  initial forever #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errTotal++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic completeRun;
    $display("checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One port cycle; a read notes its expected data
  task automatic op(logic w, logic [3:0] a, logic [31:0] d);
    swWr <= w;
    swRd <= !w;
    swAddr <= a;
    swWdata <= d;
    if (!w) expQ.push_back(d);
    @(posedge clk);
  endtask
  task automatic idle;
    swWr <= 1'h0;
    swRd <= 1'h0;
    @(posedge clk);
  endtask
  // Bounded wait on the run enable, sampled mid-cycle where it is settled
  task automatic waitEn(logic v);
    int n = 0;
    @(negedge clk);
    while (n < 20 && dmaEnable !== v) begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, dmaEnable}, {31'h0, v});
    if (dmaEnable !== v) completeRun;
    @(posedge clk);
  endtask
  // Soft reset, reconfigure, confirm flags clear
  task automatic srst;
    op(1'h1, EDM_OFS_MODE, 32'h1);
    op(1'h1, EDM_OFS_OPCTRL, 32'h8);
    op(1'h0, EDM_OFS_OPCTRL, 32'h8);
    idle;
    waitEn(1'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Read data stand in the cycle after the port read; a soft reset
  // write owes one softReset pulse in that same cycle
  always @(posedge clk) begin
    s1 <= swRd;
    s2 <= swWr && swAddr == EDM_OFS_MODE && swWdata[EDM_BIT_SOFTRST];
  end
  always @(negedge clk) begin
    if (s1) chk(swRdata, expQ.pop_front());
    chk({31'h0, softReset}, {31'h0, s2});
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    for (int k = 0; k < 5; k++) op(1'h0, 4'(k), 32'h0);
    idle;
    waitEn(1'h1);
    op(1'h1, EDM_OFS_OPCTRL, 32'h8);
    op(1'h0, EDM_OFS_OPCTRL, 32'h8);
    $display("reset and policy done");
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      live[k] <= seed;
    end
    idle;
    repeat (8) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      op(1'h1, 4'(k + 1), ~live[k]);
      op(1'h0, 4'(k + 1), live[k]);
    end
    op(1'h1, EDM_OFS_HCMD, seed);
    op(1'h0, EDM_OFS_HSTAT, live[3]);
    idle;
    $display("snapshots done");
    for (int k = 0; k < 2; k++) begin
      if (k == 0) txUf <= 1'h1;
      else rxOf <= 1'h1;
      @(posedge clk);
      txUf <= 1'h0;
      rxOf <= 1'h0;
      waitEn(1'h0);
      srst;
    end
    op(1'h1, EDM_OFS_OPCTRL, 32'h0);
    op(1'h0, EDM_OFS_OPCTRL, 32'h0);
    idle;
    txUf <= 1'h1;
    rxOf <= 1'h1;
    @(posedge clk);
    txUf <= 1'h0;
    rxOf <= 1'h0;
    repeat (6) begin
      @(negedge clk);
      chk({31'h0, dmaEnable}, 32'h1);
    end
    @(posedge clk);
    $display("fifo policy done");
    aIll <= 1'h1;
    @(posedge clk);
    aIll <= 1'h0;
    op(1'h0, EDM_OFS_OPCTRL, 32'h4);
    idle;
    waitEn(1'h0);
    srst;
    $display("address error done");
    nmiPin <= 1'h1;
    repeat (6) @(posedge clk);
    op(1'h0, EDM_OFS_OPCTRL, 32'hA);
    idle;
    waitEn(1'h0);
    op(1'h1, EDM_OFS_OPCTRL, 32'h8);
    op(1'h0, EDM_OFS_OPCTRL, 32'h8);
    idle;
    waitEn(1'h1);
    nmiPin <= 1'h0;
    $display("nmi halt done");
    repeat (6) @(posedge clk);
    completeRun;
  end
endmodule // tb
